/* verilog/tpq_pkg.sv */
/*
 * Shared constants and carrier types of the pixel quality classifier.
 * Assumes one 100 MHz clock domain and 12-bit signed phase samples.
 */
package tpq_pkg;

    // Register map
    localparam logic [7:0] MOD_DIV_ADDR  = 8'h85;
    localparam logic [7:0] MOD_DIV_RESET = 8'h01;
    localparam logic [7:0] MOD_DIV_80    = 8'h00;
    localparam logic [7:0] MOD_DIV_40    = 8'h01;
    localparam logic [7:0] MOD_DIV_20    = 8'h03;
    localparam logic [7:0] MOD_DIV_10    = 8'h07;
    localparam logic [7:0] MOD_DIV_5     = 8'h0F;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Timebase figures at divider setting 0, halved or doubled per step
    localparam int BASE_MOD_KHZ  = 80000;
    localparam int LED_PER_MOD   = 4;
    localparam int BASE_LED_KHZ  = BASE_MOD_KHZ / LED_PER_MOD;
    localparam int BASE_UNAMB_DM = 75;
    localparam int RANGE_CODES   = 3000;
    localparam int UM_PER_DM     = 100000;
    localparam int BASE_RES_UM   = BASE_UNAMB_DM * UM_PER_DM / RANGE_CODES;

    // Amplitude classes in LSB
    localparam int AMP_NOISY_LSB = 25;
    localparam int AMP_GOOD_LSB  = 100;
    localparam int AMP_OVER_LSB  = 2000;

    // Validity limits in percent of full scale
    localparam int FULL_SCALE = 2047;
    localparam int PCT_SAT    = 99;
    localparam int PCT_DARK   = 1;
    localparam int PCT_USE    = 5;

    // Ambient-to-modulated limits: 60 dB and 70 dB as linear ratios
    localparam int AMR_60_RATIO  = 1000;
    localparam int AMR_70_RATIO  = 3162;
    localparam int DB_PER_OCTAVE = 6;

    // Amplitude root width and fixed accept-to-result latency in cycles
    localparam int ROOT_W         = 13;
    localparam int RESULT_LATENCY = 56;

    typedef enum logic [1:0] {
        AMP_WEAK  = 2'h0,
        AMP_NOISY = 2'h1,
        AMP_GOOD  = 2'h2,
        AMP_OVER  = 2'h3
    } tpq_amp_class_t;

    typedef enum logic [1:0] {
        AMR_EXCELLENT  = 2'h0,
        AMR_SUFFICIENT = 2'h1,
        AMR_WEAK       = 2'h2
    } tpq_amr_class_t;

    typedef enum logic [1:0] {
        DEC_KEEP     = 2'h0,
        DEC_USE      = 2'h1,
        DEC_INCREASE = 2'h2,
        DEC_DECREASE = 2'h3
    } tpq_decision_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LOAD  = 3'h1,
        ST_SQRT  = 3'h2,
        ST_DIV   = 3'h3,
        ST_CLASS = 3'h4
    } tpq_state_t;

    typedef struct packed {
        logic               valid;
        logic               first;
        logic               overflow;
        logic signed [11:0] data;
    } tpq_sample_t;

    typedef struct packed {
        logic [4:0]  mult;
        logic [16:0] mod_khz;
        logic [14:0] led_khz;
        logic [10:0] unamb_dm;
        logic [15:0] res_um;
    } tpq_timebase_t;

    typedef struct packed {
        logic [11:0]    amplitude;
        logic [7:0]     ratio_db;
        logic [31:0]    mod_irradiance;
        tpq_amp_class_t amp_class;
        tpq_amr_class_t amr_class;
        tpq_decision_t  decision;
    } tpq_result_t;

endpackage

/* verilog/tpq_isqrt.sv */
/*
 * Bit-serial integer square root, one result bit per clock.
 * Assumes start is a single-cycle pulse and is not repeated while busy.
 */
`timescale 1ns/10ps
module tpq_isqrt #(
    parameter int RW = 13
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Request
    input  wire logic            start,
    input  wire logic [2*RW-1:0] radicand,
    // Answer
    output logic                 done,
    output logic [RW-1:0]        root
);
    localparam int IW = $clog2(RW);

    logic [2*RW-1:0] rad;
    logic [IW-1:0]   bit_idx;
    logic            running;

    wire  [RW-1:0]   bit_mask = RW'(1) << bit_idx;
    wire  [RW-1:0]   trial    = root | bit_mask;
    wire  [2*RW-1:0] trial_sq = trial * trial;

    // Fixed RW iterations keep the caller's latency constant
    always_ff @(posedge clk) begin
        if (rst) begin
            rad     <= '0;
            root    <= '0;
            bit_idx <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rad     <= radicand;
                root    <= '0;
                bit_idx <= IW'(RW - 1);
                running <= 1'b1;
            end else if (running) begin
                if (trial_sq <= rad) begin
                    root <= trial;
                end
                if (bit_idx == '0) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    bit_idx <= bit_idx - IW'(1);
                end
            end
        end
    end
endmodule // tpq_isqrt

/* verilog/tpq_classifier.sv */
/*
 * Per-pixel time-of-flight quality classifier with modulation divider register.
 * Assumes samples arrive in phase order zero to three, synchronous to clk.
 */
`timescale 1ns/10ps
module tpq_classifier #(
    parameter int SENS_W = 12,
    parameter int TREF_W = 16,
    parameter int TINT_W = 16,
    parameter int AMB_W  = 32
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Register port
    input  wire logic                   reg_wr,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic [7:0]                  reg_rdata,
    // Sample stream
    input  wire tpq_pkg::tpq_sample_t   sample,
    output logic                        sample_ready,
    // Measurement context, taken with the last sample
    input  wire logic [SENS_W-1:0]      ac_sensitivity,
    input  wire logic [TREF_W-1:0]      int_time_ref,
    input  wire logic [TINT_W-1:0]      int_time_used,
    input  wire logic [AMB_W-1:0]       ambient_irradiance,
    // Results
    output logic                        result_valid,
    output tpq_pkg::tpq_result_t        result,
    output tpq_pkg::tpq_timebase_t      timebase
);
    localparam int NUM_W = SENS_W + TREF_W + 12;
    localparam int DEN_W = TINT_W + 5;
    localparam int CW    = $clog2(NUM_W);

    function automatic logic div_legal(input logic [7:0] v);
        return v == tpq_pkg::MOD_DIV_80 || v == tpq_pkg::MOD_DIV_40 ||
               v == tpq_pkg::MOD_DIV_20 || v == tpq_pkg::MOD_DIV_10 ||
               v == tpq_pkg::MOD_DIV_5;
    endfunction

    function automatic logic pct_above(input logic [12:0] x, input int p);
        return 32'(x) * 32'd100 > 32'(p * tpq_pkg::FULL_SCALE);
    endfunction

    function automatic logic pct_below(input logic [12:0] x, input int p);
        return 32'(x) * 32'd100 < 32'(p * tpq_pkg::FULL_SCALE);
    endfunction

    function automatic logic [12:0] mag(input logic signed [11:0] s);
        return s[11] ? 13'(-{s[11], s}) : {1'b0, s};
    endfunction

    function automatic logic [5:0] msb_index(input logic [31:0] v);
        logic [5:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) r = 6'(i);
        end
        return r;
    endfunction

    logic [7:0]               mod_clk_divider;
    tpq_pkg::tpq_state_t      state;
    logic [1:0]               idx;
    logic signed [11:0]       smp [4];
    logic                     any_overflow;
    logic                     any_bright;
    logic                     all_dark;
    logic [AMB_W-1:0]         amb_q;
    logic [DEN_W-1:0]         den;
    logic [SENS_W+TREF_W-1:0] sens_ref;
    logic [11:0]              amp;
    logic [NUM_W-1:0]         quo_num;
    logic [DEN_W:0]           rem;
    logic [CW-1:0]            div_cnt;
    logic                     sqrt_done;
    logic [12:0]              sqrt_root;

    // Register port and timebase decode
    wire       div_wr   = reg_wr && reg_addr == tpq_pkg::MOD_DIV_ADDR && div_legal(reg_wdata);
    wire [2:0] tb_shift = 3'(mod_clk_divider[0]) + 3'(mod_clk_divider[1]) +
                          3'(mod_clk_divider[2]) + 3'(mod_clk_divider[3]);

    always_ff @(posedge clk) begin
        if (rst) begin
            mod_clk_divider <= tpq_pkg::MOD_DIV_RESET;
            reg_rdata       <= '0;
            timebase        <= '0;
        end else begin
            if (div_wr) begin
                mod_clk_divider <= reg_wdata;
            end
            reg_rdata <= reg_addr == tpq_pkg::MOD_DIV_ADDR ? mod_clk_divider
                                                           : tpq_pkg::UNMAPPED_READ;
            timebase.mult     <= 5'(1) << tb_shift;
            timebase.mod_khz  <= 17'(tpq_pkg::BASE_MOD_KHZ) >> tb_shift;
            timebase.led_khz  <= 15'(tpq_pkg::BASE_LED_KHZ) >> tb_shift;
            timebase.unamb_dm <= 11'(tpq_pkg::BASE_UNAMB_DM) << tb_shift;
            timebase.res_um   <= 16'(tpq_pkg::BASE_RES_UM) << tb_shift;
        end
    end

    // Sample intake: a first-flagged sample restarts the set at phase zero
    wire        fire      = sample.valid && sample_ready;
    wire [1:0]  cur_idx   = sample.first ? 2'h0 : idx;
    wire        last_fire = fire && cur_idx == 2'h3;
    wire [12:0] smag      = mag(sample.data);
    wire        s_bright  = pct_above(smag, tpq_pkg::PCT_SAT);
    wire        s_dark    = !pct_above(smag, tpq_pkg::PCT_DARK);

    // Amplitude radicand from the stored phase samples
    wire signed [12:0] d20      = {smp[2][11], smp[2]} - {smp[0][11], smp[0]};
    wire signed [12:0] d31      = {smp[3][11], smp[3]} - {smp[1][11], smp[1]};
    wire signed [25:0] sq20     = d20 * d20;
    wire signed [25:0] sq31     = d31 * d31;
    wire        [25:0] radicand = $unsigned(sq20) + $unsigned(sq31);

    tpq_isqrt #(
        .RW       (tpq_pkg::ROOT_W)
    ) u_isqrt (
        .clk      (clk),
        .rst      (rst),
        .start    (state == tpq_pkg::ST_LOAD),
        .radicand (radicand),
        .done     (sqrt_done),
        .root     (sqrt_root)
    );

    // Restoring divider for sensitivity * reference time * amplitude / (used time * timebase multiplier)
    wire [DEN_W:0] shifted_rem = {rem[DEN_W-1:0], quo_num[NUM_W-1]};
    wire           fits        = shifted_rem >= {1'b0, den};
    wire [DEN_W:0] next_rem    = fits ? shifted_rem - {1'b0, den} : shifted_rem;
    wire [NUM_W-1:0] dividend  = NUM_W'(sens_ref * sqrt_root[12:1]);

    // A zero divisor saturates the quotient rather than faulting
    wire [31:0] etof = |quo_num[NUM_W-1:32] ? '1 : quo_num[31:0];

    // Ratio and classes, evaluated in ST_CLASS
    wire [AMB_W+11:0] amb_w   = (AMB_W + 12)'(amb_q);
    wire [AMB_W+11:0] lim_70  = (AMB_W + 12)'(etof) * (AMB_W + 12)'(tpq_pkg::AMR_70_RATIO);
    wire [AMB_W+11:0] lim_60  = (AMB_W + 12)'(etof) * (AMB_W + 12)'(tpq_pkg::AMR_60_RATIO);
    wire              amr_wk  = amb_w > lim_70;
    wire              amr_ex  = amb_w < lim_60;
    wire signed [6:0] oct     = 7'(msb_index(32'(amb_q))) - 7'(msb_index(etof));
    // Octave count gives roughly 6 dB steps; exact logs are not worth the area
    wire [7:0]        amr_db  = oct[6] ? 8'h00 : 8'(oct) * 8'(tpq_pkg::DB_PER_OCTAVE);
    wire [12:0]       amp13   = {1'b0, amp};
    wire              amp_hi  = pct_above(amp13, tpq_pkg::PCT_SAT);
    wire              amp_lo  = pct_below(amp13, tpq_pkg::PCT_DARK);
    wire              amp_use = !pct_below(amp13, tpq_pkg::PCT_USE) && !amp_hi;

    tpq_pkg::tpq_amp_class_t amp_cls;
    tpq_pkg::tpq_amr_class_t amr_cls;
    tpq_pkg::tpq_decision_t  decision;

    assign amp_cls = amp < 12'(tpq_pkg::AMP_NOISY_LSB) ? tpq_pkg::AMP_WEAK  :
                     amp < 12'(tpq_pkg::AMP_GOOD_LSB)  ? tpq_pkg::AMP_NOISY :
                     amp > 12'(tpq_pkg::AMP_OVER_LSB)  ? tpq_pkg::AMP_OVER  : tpq_pkg::AMP_GOOD;
    assign amr_cls = amr_wk ? tpq_pkg::AMR_WEAK :
                     amr_ex ? tpq_pkg::AMR_EXCELLENT : tpq_pkg::AMR_SUFFICIENT;
    // Steps in priority order: overflow, samples, amplitude, ratio
    assign decision = any_overflow       ? tpq_pkg::DEC_DECREASE :
                      any_bright         ? tpq_pkg::DEC_DECREASE :
                      all_dark           ? tpq_pkg::DEC_INCREASE :
                      amp_hi             ? tpq_pkg::DEC_DECREASE :
                      amp_lo             ? tpq_pkg::DEC_INCREASE :
                      amr_wk             ? tpq_pkg::DEC_DECREASE :
                      amp_use && amr_ex  ? tpq_pkg::DEC_USE : tpq_pkg::DEC_KEEP;

    // Next state
    tpq_pkg::tpq_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            tpq_pkg::ST_IDLE:  if (last_fire) next_state = tpq_pkg::ST_LOAD;
            tpq_pkg::ST_LOAD:  next_state = tpq_pkg::ST_SQRT;
            tpq_pkg::ST_SQRT:  if (sqrt_done) next_state = tpq_pkg::ST_DIV;
            tpq_pkg::ST_DIV:   if (div_cnt == '0) next_state = tpq_pkg::ST_CLASS;
            tpq_pkg::ST_CLASS: next_state = tpq_pkg::ST_IDLE;
            default:           next_state = tpq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state        <= tpq_pkg::ST_IDLE;
            sample_ready <= 1'b0;
            idx          <= '0;
            smp          <= '{default: '0};
            any_overflow <= 1'b0;
            any_bright   <= 1'b0;
            all_dark     <= 1'b0;
            amb_q        <= '0;
            den          <= '0;
            sens_ref     <= '0;
            amp          <= '0;
            quo_num      <= '0;
            rem          <= '0;
            div_cnt      <= '0;
            result_valid <= 1'b0;
            result       <= '0;
        end else begin
            state        <= next_state;
            sample_ready <= next_state == tpq_pkg::ST_IDLE;
            result_valid <= 1'b0;
            if (fire) begin
                idx          <= cur_idx + 2'h1;
                smp[cur_idx] <= sample.data;
                any_overflow <= sample.overflow || (cur_idx != 2'h0 && any_overflow);
                any_bright   <= s_bright || (cur_idx != 2'h0 && any_bright);
                all_dark     <= s_dark && (cur_idx == 2'h0 || all_dark);
            end
            if (last_fire) begin
                amb_q    <= ambient_irradiance;
                den      <= DEN_W'(int_time_used * timebase.mult);
                sens_ref <= (SENS_W + TREF_W)'(ac_sensitivity * int_time_ref);
            end
            if (state == tpq_pkg::ST_SQRT && sqrt_done) begin
                amp     <= sqrt_root[12:1];
                quo_num <= dividend;
                rem     <= '0;
                div_cnt <= CW'(NUM_W - 1);
            end
            if (state == tpq_pkg::ST_DIV) begin
                rem     <= next_rem;
                quo_num <= {quo_num[NUM_W-2:0], fits};
                div_cnt <= div_cnt - CW'(1);
            end
            if (state == tpq_pkg::ST_CLASS) begin
                result_valid          <= 1'b1;
                result.amplitude      <= amp;
                result.ratio_db       <= amr_db;
                result.mod_irradiance <= etof;
                result.amp_class      <= amp_cls;
                result.amr_class      <= amr_cls;
                result.decision       <= decision;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    localparam int RES_LAT = tpq_pkg::RESULT_LATENCY + 1;  // Strobe is sampled one edge after launch

    sequence s_set_done;
        last_fire;
    endsequence

    sequence s_root_ready;
        ##1 (state == tpq_pkg::ST_LOAD) ##14 sqrt_done;
    endsequence

    a_reset_divider: assert property ($past(rst) |-> mod_clk_divider == 8'h01)
        else $error("divider not at its reset setting");
    a_divider_legal: assert property (div_legal(mod_clk_divider))
        else $error("divider holds an unlisted setting");
    a_timebase_mult: assert property (##1 $stable(mod_clk_divider) |->
        32'(timebase.mult) == 32'(mod_clk_divider) + 1 &&
        32'(timebase.led_khz) * 4 == 32'(timebase.mod_khz))
        else $error("timebase multiplier or LED frequency wrong");
    a_range_res: assert property (32'(timebase.res_um) * 3000 ==
        32'(timebase.unamb_dm) * 100000 && 32'(timebase.unamb_dm) == 75 * 32'(timebase.mult))
        else $error("resolution or unambiguity distance wrong");
    a_root_timing: assert property (s_set_done |-> s_root_ready)
        else $error("amplitude root not ready on time");
    a_result_latency: assert property (s_set_done |-> ##RES_LAT result_valid)
        else $error("result strobe late or missing");
    a_result_cause: assert property (result_valid |-> $past(last_fire, RES_LAT))
        else $error("result strobe without a sample set");
    a_amp_class: assert property (result_valid && result.amp_class == tpq_pkg::AMP_GOOD |->
        result.amplitude >= 12'd100 && result.amplitude <= 12'd2000)
        else $error("amplitude class does not match amplitude");
    a_overflow_first: assert property ($rose(state == tpq_pkg::ST_CLASS) && any_overflow |=>
        result_valid && result.decision == tpq_pkg::DEC_DECREASE)
        else $error("overflowed pixel not told to decrease");
    a_use_quality: assert property (result_valid && result.decision == tpq_pkg::DEC_USE |->
        result.amr_class == tpq_pkg::AMR_EXCELLENT && result.amplitude > 12'd102)
        else $error("distance used with poor quality");
endmodule // tpq_classifier

/* sim/tpq_imager_model.sv */
/*
 * Imager stand-in: streams four phase samples per pixel with overflow flags.
 * Assumes the classifier takes a sample on a rising edge with valid and ready.
 */
`timescale 1ns/10ps
module tpq_imager_model (
    // Clock
    input  wire logic            clk,
    // Stream
    input  wire logic            sample_ready,
    output tpq_pkg::tpq_sample_t sample
);
    initial sample = '0;

    // Holds each sample until taken; gap idles between samples model a slow imager
    task automatic send_set(input logic [47:0] s, input int ovf, input int cnt, input int gap);
        @(negedge clk);
        for (int i = 0; i < cnt; i++) begin
            sample.valid    = 1'b1;
            sample.first    = (i == 0);
            sample.overflow = (i == ovf);
            sample.data     = s[47-12*i -: 12];
            while (!sample_ready) @(negedge clk);
            @(negedge clk);
            if (gap > 0 || i == cnt - 1) begin
                sample.valid = 1'b0;
                // Released data is scrambled so stale values cannot pass
                sample.data  = ~sample.data;
                if (i < cnt - 1) repeat (gap) @(negedge clk);
            end
        end
    endtask
endmodule // tpq_imager_model

/* sim/tpq_classifier_test.sv */
/*
 * Self-checking bench: divider register, timebase and pixel classification.
 * Assumes the imager model is compiled before this file.
 */
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tpq_classifier_test;
    logic                   clk = 1'b0;
    logic                   rst;
    logic                   reg_wr;
    logic [7:0]             reg_addr;
    logic [7:0]             reg_wdata;
    logic [7:0]             reg_rdata;
    tpq_pkg::tpq_sample_t   sample;
    logic                   sample_ready;
    logic [11:0]            ac_sensitivity;
    logic [15:0]            int_time_ref;
    logic [15:0]            int_time_used;
    logic [31:0]            ambient_irradiance;
    logic                   result_valid;
    tpq_pkg::tpq_result_t   result;
    tpq_pkg::tpq_timebase_t timebase;
    int                     num_errors = 0;
    int                     num_checks = 0;
    int                     n;
    int                     mults [5] = '{1, 2, 4, 8, 16};
    logic [47:0]            sets [8] = '{48'h000_000_258_320, 48'h000_000_258_320,
        48'h00A_00A_00A_00A, 48'h7F8_000_000_000, 48'h000_000_258_320,
        48'h000_000_064_000, 48'h808_000_7F8_000, 48'h000_000_028_000};
    int                     ovf [8] = '{-1, 2, -1, -1, -1, -1, -1, -1};
    int                     amb [8] = '{0, 0, 0, 0, 1000000, 50000, 0, 0};
    int                     amp [8] = '{500, 500, 0, 1020, 500, 50, 2040, 20};
    int                     cls [8] = '{2, 2, 0, 2, 2, 1, 3, 0};
    int                     ambient_to_modulated_ratio [8] = '{0, 0, 3, 0, 2, 1, 0, 0};
    int                     rdb [8] = '{0, 0, 0, 0, 72, 66, 0, 0};
    int                     dec [8] = '{1, 3, 2, 3, 3, 0, 3, 2};

    always #5 clk = ~clk;

    tpq_classifier uut (
        .clk                (clk),
        .rst                (rst),
        .reg_wr             (reg_wr),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_rdata          (reg_rdata),
        .sample             (sample),
        .sample_ready       (sample_ready),
        .ac_sensitivity     (ac_sensitivity),
        .int_time_ref       (int_time_ref),
        .int_time_used      (int_time_used),
        .ambient_irradiance (ambient_irradiance),
        .result_valid       (result_valid),
        .result             (result),
        .timebase           (timebase)
    );

    tpq_imager_model imager (
        .clk          (clk),
        .sample_ready (sample_ready),
        .sample       (sample)
    );

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // Read data is registered, so the address is held one edge first
    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        @(negedge clk);
        `CHK(reg_rdata, exp)
    endtask

    function automatic tpq_pkg::tpq_timebase_t tb_exp(input int m);
        tb_exp.mult     = 5'(m);
        tb_exp.mod_khz  = 17'(80000 / m);
        tb_exp.led_khz  = 15'(20000 / m);
        tb_exp.unamb_dm = 11'(75 * m);
        tb_exp.res_um   = 16'(2500 * m);
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        rst                = 1'b1;
        reg_wr             = 1'b0;
        reg_addr           = 8'h85;
        reg_wdata          = 8'h00;
        ac_sensitivity     = 12'h001;
        int_time_ref       = 16'h0064;
        int_time_used      = 16'h0064;
        ambient_irradiance = 32'h0000_0000;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        reg_check(tpq_pkg::MOD_DIV_ADDR, 8'h01);
        `CHK(timebase, tb_exp(2))
        for (int i = 0; i < 5; i++) begin
            reg_write(tpq_pkg::MOD_DIV_ADDR, 8'(mults[i] - 1));
            reg_check(tpq_pkg::MOD_DIV_ADDR, 8'(mults[i] - 1));
            `CHK(timebase, tb_exp(mults[i]))
        end
        reg_write(tpq_pkg::MOD_DIV_ADDR, 8'h02);
        reg_write(8'h86, 8'h03);
        reg_check(tpq_pkg::MOD_DIV_ADDR, 8'h0F);
        reg_check(8'h84, 8'h00);
        reg_write(tpq_pkg::MOD_DIV_ADDR, 8'h01);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            ambient_irradiance = 32'(amb[i]);
            // An unfinished set must be dropped when a new first sample comes
            if (i == 0) imager.send_set(48'h123_456_000_000, -1, 2, 0);
            imager.send_set(sets[i], ovf[i], 4, i % 2);
            `CHK(sample_ready, 1'b0)
            n = 0;
            while (result_valid !== 1'b1 && n < 200) begin
                @(negedge clk);
                n++;
            end
            `CHK(n, tpq_pkg::RESULT_LATENCY)
            `CHK(sample_ready, 1'b1)
            `CHK(result.ratio_db, 8'(rdb[i]))
            `CHK(result.amplitude, 12'(amp[i]))
            `CHK(result.amp_class, 2'(cls[i]))
            `CHK(result.mod_irradiance, 32'(amp[i] / 2))
            if (ambient_to_modulated_ratio[i] != 3) `CHK(result.amr_class, 2'(ambient_to_modulated_ratio[i]))
            `CHK(result.decision, 2'(dec[i]))
            // A controller aiming for the target band yields usable distances
            if (dec[i] == 1) `CHK(result.amplitude inside {[12'd200:12'd1500]}, 1'b1)
            $display("test pixel set %0d done", i);
        end
        report_and_stop();
    end
endmodule // tpq_classifier_test
